// ===== hdl/srt_mpr_defs.vh
// Purpose: constants for the self-refresh rate and readout-mode block
// Assumes: included by its bare name from every design file
// Notes: offsets are byte addresses on a 32-bit classic Wishbone bus
`ifndef SRT_MPR_DEFS_VH
`define SRT_MPR_DEFS_VH

// ==========================================================
// Register byte offsets
`define REG_MODE_TWO     32'h0000_0000
`define REG_MODE_THREE   32'h0000_0004
`define REG_STATUS       32'h0000_0008
`define REG_RATE_PERIOD  32'h0000_000C

// ==========================================================
// Field positions
`define TWO_RATE_BIT     7
`define THREE_READOUT_BIT 2
`define MR3_LOC_LSB      0
`define ST_RATE2X_BIT    0
`define ST_MPR_BIT       1
`define ST_HIGHTEMP_BIT  2
`define ST_SRVALID_BIT   3
`define ST_CMDSEEN_BIT   4

// ==========================================================
// Reset values
`define TWO_RESET        16'h0000
`define THREE_RESET      16'h0000

// ==========================================================
// Temperature limits in degrees C, signed 8 bit
`define TEMP_NORMAL_MAX  8'h55
`define TEMP_EXT_MAX     8'h5F
`define TEMP_MIN         8'hD8

// ==========================================================
// Timing: self-refresh period in ns and cycles at 100 ns
`define CLK_PERIOD_NS    100
`define SR_1X_NS         7800
`define SR_2X_NS         3900
`define SR_1X_CYCLES     (`SR_1X_NS / `CLK_PERIOD_NS)
`define SR_2X_CYCLES     (`SR_2X_NS / `CLK_PERIOD_NS)

// ==========================================================
// Readout pattern (arbitrary neutral training pattern)
`define READOUT_PATTERN0 16'h5555
`define READOUT_PATTERN1 16'h3333
`define READOUT_PATTERN2 16'h0F0F
`define READOUT_PATTERN3 16'h00FF

`endif

// ===== hdl/refresh_timer.v
// Purpose: self-refresh tick generator with selectable 1x or 2x rate
// Assumes: single clock, synchronous active-high reset
// Notes: period is compared live every cycle, so a rate change acts on the current count at once
`timescale 1ns/1ps
`include "srt_mpr_defs.vh"

module refresh_timer
#(
  parameter CNT_W = 16
)
(
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // Control
  input  wire             run_i,
  input  wire             rate_2x_i,
  // Result
  output reg              tick_o,
  output reg  [CNT_W-1:0] period_o
);

  wire [CNT_W-1:0] period_1x;
  wire [CNT_W-1:0] period_2x;
  wire [CNT_W-1:0] period_sel;
  reg  [CNT_W-1:0] count;

  // Full-width copies so the period can be cut to the counter width on purpose
  localparam [31:0] PERIOD_1X_FULL = `SR_1X_CYCLES;
  localparam [31:0] PERIOD_2X_FULL = `SR_2X_CYCLES;

  assign period_1x  = PERIOD_1X_FULL[CNT_W-1:0];
  assign period_2x  = PERIOD_2X_FULL[CNT_W-1:0];
  assign period_sel = rate_2x_i ? period_2x : period_1x;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count    <= {CNT_W{1'b0}};
      tick_o   <= 1'b0;
      period_o <= {CNT_W{1'b0}};
    end
    else
    begin
      period_o <= period_sel;
      tick_o   <= 1'b0;
      if (!run_i)
        count <= {CNT_W{1'b0}};
      else if (count >= period_sel - 1'b1)
      begin
        count  <= {CNT_W{1'b0}};
        tick_o <= 1'b1;
      end
      else
        count <= count + 1'b1;
    end
  end

endmodule // refresh_timer

// ===== hdl/srt_mpr_regs.v
// Purpose: mode registers two and three, self-refresh rate, readout-mode read path
// Assumes: command pins sampled synchronously to clk_i; active-low pins
// Notes: Wishbone slave gives software a view and a load path for the same registers
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "srt_mpr_defs.vh"

module srt_mpr_regs
#(
  parameter DATA_W = 16,
  parameter ADDR_W = 16
)
(
  // Clock and reset
  input  wire              clk_i,
  input  wire              rst_i,
  // Command and address pins
  input  wire              cs_n_i,
  input  wire              ras_n_i,
  input  wire              cas_n_i,
  input  wire              we_n_i,
  input  wire [2:0]        ba_i,
  input  wire [ADDR_W-1:0] addr_i,
  // Read path
  input  wire              rd_i,
  input  wire [DATA_W-1:0] array_data_i,
  output reg  [DATA_W-1:0] rd_data_o,
  output reg               rd_valid_o,
  output reg               rd_from_pattern_o,
  // Self-refresh
  input  wire              self_refresh_i,
  input  wire [7:0]        case_temperature_i,
  output reg               sr_tick_o,
  output reg               sr_rate_2x_o,
  output reg               sr_valid_o,
  // Wishbone slave
  input  wire              cyc_i,
  input  wire              stb_i,
  input  wire              we_i,
  input  wire [31:0]       adr_i,
  input  wire [3:0]        sel_i,
  input  wire [31:0]       dat_i,
  output reg  [31:0]       dat_o,
  output reg               ack_o
);

  // ==========================================================
  // State
  reg  [15:0]       mode_register_two;
  reg  [15:0]       mode_register_three;
  reg               cmd_seen;
  wire              load_mr2;
  wire              load_mr3;
  wire              multipurpose_readout;
  wire [1:0]        readout_loc;
  wire              self_refresh_temp_range;
  wire              tick;
  wire [15:0]       period;
  wire              high_temp;
  wire              temp_ok;
  reg  [DATA_W-1:0] next_rd_data;
  reg  [31:0]       next_dat;
  wire              wb_req;
  wire              wb_wr;

  // ==========================================================
  // Command decode: mode register set with bank select
  assign load_mr3 = !cs_n_i && !ras_n_i && !cas_n_i && !we_n_i
                    && (ba_i == 3'b011);
  assign load_mr2 = !cs_n_i && !ras_n_i && !cas_n_i && !we_n_i
                    && (ba_i == 3'b010);

  // ==========================================================
  // Mode field extraction
  // The rate bit is the only field of register two acted on here; the
  // other fields are kept so software reads back what was loaded.
  assign self_refresh_temp_range = mode_register_two[`TWO_RATE_BIT];
  assign multipurpose_readout    = mode_register_three[`THREE_READOUT_BIT];
  // Location only matters while readout is on; forcing zero otherwise
  // keeps stale location bits from leaking into the read mux
  assign readout_loc = multipurpose_readout ? mode_register_three[1:0] : 2'b00;

  // ==========================================================
  // Temperature view
  // Limitation: only the upper limit is checked; the lower limit of the
  // valid range is left to the system.

  // Signed compare: high temp means above 85C
  assign high_temp = ($signed(case_temperature_i) > $signed(`TEMP_NORMAL_MAX));
  assign temp_ok   = self_refresh_temp_range
                     ? ($signed(case_temperature_i) <= $signed(`TEMP_EXT_MAX))
                     : !high_temp;

  assign wb_req = cyc_i && stb_i && !ack_o;
  assign wb_wr  = wb_req && we_i;

  // ==========================================================
  // Mode registers; pin loads win over a bus write in the same cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_register_two   <= `TWO_RESET;
      mode_register_three <= `THREE_RESET;
      cmd_seen            <= 1'b0;
    end
    else
    begin
      if (load_mr2)
        mode_register_two <= addr_i[15:0];
      else if (wb_wr && adr_i == `REG_MODE_TWO)
      begin
        if (sel_i[0])
          mode_register_two[7:0] <= dat_i[7:0];
        if (sel_i[1])
          mode_register_two[15:8] <= dat_i[15:8];
      end
      // Reserved bits stored as given; the controller must send zero there
      if (load_mr3)
        mode_register_three <= addr_i[15:0];
      else if (wb_wr && adr_i == `REG_MODE_THREE)
      begin
        if (sel_i[0])
          mode_register_three[7:0] <= dat_i[7:0];
        if (sel_i[1])
          mode_register_three[15:8] <= dat_i[15:8];
      end
      // Sticky; a pin load in the clearing cycle wins
      if (load_mr2 || load_mr3)
        cmd_seen <= 1'b1;
      else if (wb_wr && adr_i == `REG_STATUS && sel_i[0] && dat_i[`ST_CMDSEEN_BIT])
        cmd_seen <= 1'b0;
    end
  end

  // ==========================================================
  // Self-refresh timer
  refresh_timer
  #(
    .CNT_W (16)
  )
  u_timer
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .run_i     (self_refresh_i),
    .rate_2x_i (self_refresh_temp_range),
    .tick_o    (tick),
    .period_o  (period)
  );

  // ==========================================================
  // Read path
  always @*
  begin
    next_rd_data = array_data_i;
    if (multipurpose_readout)
    begin
      case (readout_loc)
        2'b00:   next_rd_data = `READOUT_PATTERN0;
        2'b01:   next_rd_data = `READOUT_PATTERN1;
        2'b10:   next_rd_data = `READOUT_PATTERN2;
        default: next_rd_data = `READOUT_PATTERN3;
      endcase
    end
  end

  // ==========================================================
  // Bus read mux; unmapped addresses read zero and still ack
  always @*
  begin
    next_dat = 32'h0000_0000;
    if (adr_i == `REG_MODE_TWO)
      next_dat = {16'h0000, mode_register_two};
    else if (adr_i == `REG_MODE_THREE)
      next_dat = {16'h0000, mode_register_three};
    else if (adr_i == `REG_STATUS)
      next_dat = {27'h0000000, cmd_seen, temp_ok, high_temp,
                  multipurpose_readout, self_refresh_temp_range};
    else if (adr_i == `REG_RATE_PERIOD)
      next_dat = {16'h0000, period};
  end

  // ==========================================================
  // Registered outputs
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_data_o         <= {DATA_W{1'b0}};
      rd_valid_o        <= 1'b0;
      rd_from_pattern_o <= 1'b0;
      sr_tick_o         <= 1'b0;
      sr_rate_2x_o      <= 1'b0;
      sr_valid_o        <= 1'b0;
      dat_o             <= 32'h0000_0000;
      ack_o             <= 1'b0;
    end
    else
    begin
      rd_valid_o        <= rd_i;
      rd_from_pattern_o <= rd_i && multipurpose_readout;
      if (rd_i)
        rd_data_o <= next_rd_data;
      sr_tick_o    <= tick;
      sr_rate_2x_o <= self_refresh_temp_range;
      sr_valid_o   <= temp_ok;
      ack_o        <= wb_req;
      if (wb_req && !we_i)
        dat_o <= next_dat;
    end
  end

endmodule // srt_mpr_regs

// ===== bench/srt_mpr_asserts.sv
// Purpose: checks on mode loads, read path, bus answer, refresh validity
// Assumes: mode registers are loaded from the pins only
// Notes: keeps its own copy of the mode bits
`timescale 1ns/1ps
module srt_mpr_asserts
(
  // Pins and read path
  input        clk_i, rst_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, rd_i,
  input [2:0]  ba_i,
  input [15:0] addr_i, array_data_i, rd_data_o,
  input [7:0]  case_temperature_i,
  // Outputs and bus
  input        rd_valid_o, rd_from_pattern_o, sr_rate_2x_o, sr_valid_o, sr_tick_o, cyc_i, stb_i, ack_o
);
  // ====
  // Shadow mode bits
  wire        ld  = !(cs_n_i | ras_n_i | cas_n_i | we_n_i);
  wire        ld2 = ld && ba_i == 3'h2;
  wire        ld3 = ld && ba_i == 3'h3;
  wire [63:0] pt  = {16'h00FF, 16'h0F0F, 16'h3333, 16'h5555};
  reg         rate_bit, readout_bit;
  reg  [1:0]  loc;
  always @(posedge clk_i)
    if (rst_i)
      {rate_bit, readout_bit, loc} <= 4'h0;
    else
    begin
      if (ld2)
        rate_bit <= addr_i[7];
      if (ld3)
        {readout_bit, loc} <= addr_i[2:0];
    end
  // ====
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rate; ld2 |=> ##1 sr_rate_2x_o == $past(addr_i[7], 2); endproperty
  a_rate: assert property (p_rate) else $error("rate flag wrong");
  property p_hold; $changed(sr_rate_2x_o) |-> $past(ld2, 2); endproperty
  a_hold: assert property (p_hold) else $error("rate flag moved");
  property p_pat; rd_i && readout_bit |=> rd_from_pattern_o && rd_data_o == pt[loc*16 +: 16]; endproperty
  a_pat: assert property (p_pat) else $error("pattern read wrong");
  property p_arr; rd_i && !readout_bit |=> !rd_from_pattern_o && rd_data_o == $past(array_data_i); endproperty
  a_arr: assert property (p_arr) else $error("array read wrong");
  property p_rdv; rd_valid_o == $past(rd_i); endproperty
  a_rdv: assert property (p_rdv) else $error("read valid wrong");
  property p_valid; !$past(rst_i) && $stable(rate_bit)
    |-> sr_valid_o == ($signed($past(case_temperature_i)) <= (rate_bit ? 8'sh5F : 8'sh55)); endproperty
  a_valid: assert property (p_valid) else $error("validity wrong");
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_ack1; ack_o |=> !ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("ack too long");
  c_pat: cover property (rd_i && readout_bit);
  c_fast: cover property (sr_tick_o && sr_rate_2x_o);
  c_ack: cover property (ack_o);
endmodule // srt_mpr_asserts

bind srt_mpr_regs srt_mpr_asserts srt_mpr_asserts_inst (.*);

// ===== bench/ctrl_model.sv
// Purpose: controller side issuing mode-register loads on the command pins
// Assumes: called just after a rising edge
// Notes: released pins show inverted values, never the last load
`timescale 1ns/1ps
module ctrl_model
(
  // Clock
  input             clk_i,
  // Command and address pins
  output reg [3:0]  cmd_n_o = 4'hF,
  output reg [2:0]  ba_o = 3'h0,
  output reg [15:0] addr_o = 16'h0000
);
  // External refresh interval in 100 ns cycles: halved above 85C
  function int refresh_gap(input hot);
    refresh_gap = hot ? 39 : 78;
  endfunction
  task mrs(input [2:0] b, input [15:0] v);
    cmd_n_o <= 4'h0;
    ba_o <= b;
    addr_o <= (b == 3'h3) ? (v & 16'h0007) : v;
    @(posedge clk_i);
    cmd_n_o <= 4'hF;
    ba_o <= ~b;
    addr_o <= ~v;
  endtask
endmodule // ctrl_model

// ===== bench/tb_top.sv
// Purpose: self-checking bench for srt_mpr_regs
// Assumes: 10 MHz clock, reset held 5 cycles
// Notes: read cases come from a row table
`timescale 1ns/1ps
module tb_top;
  reg         clk_i = 0, rst_i = 1, rd_i = 0, self_refresh_i = 0, cyc_i = 0, stb_i = 0, we_i = 0;
  reg  [15:0] array_data_i = 16'h0000;
  reg  [7:0]  case_temperature_i = 8'h19;
  reg  [31:0] adr_i = 32'h0, dat_i = 32'h0, q;
  wire [3:0]  sel_i = 4'hF, c;
  wire [2:0]  ba;
  wire [15:0] addr, rd_data_o;
  wire [31:0] dat_o;
  wire        rd_valid_o, rd_from_pattern_o, sr_tick_o, sr_rate_2x_o, sr_valid_o, ack_o;
  int         error_cnt = 0, compares = 0, cyc_cnt = 0, n;
  // Readout mode bits above the expected read data
  reg  [18:0] rows [5] = '{19'h45555, 19'h53333, 19'h60F0F, 19'h700FF, 19'h3A5C3};
  ctrl_model ctrl_model_inst (.clk_i, .cmd_n_o(c), .ba_o(ba), .addr_o(addr));
  srt_mpr_regs srt_mpr_regs_inst (.clk_i, .rst_i, .cs_n_i(c[3]), .ras_n_i(c[2]), .cas_n_i(c[1]),
    .we_n_i(c[0]), .ba_i(ba), .addr_i(addr), .rd_i, .array_data_i, .rd_data_o, .rd_valid_o,
    .rd_from_pattern_o, .self_refresh_i, .case_temperature_i, .sr_tick_o, .sr_rate_2x_o, .sr_valid_o,
    .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o);
  always #50 clk_i = ~clk_i;
  // ====
  // Tasks
  task chk(input string s, input [31:0] e, input [31:0] v);
    compares++;
    if (v !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", s, e, v);
    end
  endtask
  task wb(input w, input [31:0] a, input [31:0] d);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1)
      @(posedge clk_i);
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  // Released array data is inverted so a stale value cannot pass
  task rd(input [15:0] e);
    rd_i <= 1;
    array_data_i <= 16'hA5C3;
    @(posedge clk_i);
    rd_i <= 0;
    array_data_i <= 16'h5A3C;
    @(posedge clk_i);
    chk("rd_data", e, rd_data_o);
  endtask
  task gap(input [31:0] e);
    n = 1;
    while (sr_tick_o !== 1'b1)
      @(posedge clk_i);
    @(posedge clk_i);
    while (sr_tick_o !== 1'b1)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("tick_gap", e, n);
  endtask
  task conclude;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 3000)
    begin
      error_cnt++;
      conclude;
    end
  end
  // ====
  // Sequence
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, 32'h0, 32'h0);
    chk("mr2_reset", 32'h0, q);
    foreach (rows[i])
    begin
      ctrl_model_inst.mrs(3'h3, {13'h0000, rows[i][18:16]});
      @(posedge clk_i);
      rd(rows[i][15:0]);
    end
    wb(0, 32'h4, 32'h0);
    chk("mr3_view", 32'h3, q);
    self_refresh_i <= 1;
    gap(78);
    ctrl_model_inst.mrs(3'h2, 16'h0080);
    gap(39);
    chk("rate_2x", 1, sr_rate_2x_o);
    case_temperature_i <= 8'h5A;
    repeat (2) @(posedge clk_i);
    chk("valid_hot", 1, sr_valid_o);
    chk("ext_refresh", 39, ctrl_model_inst.refresh_gap(1));
    self_refresh_i <= 0;
    ctrl_model_inst.mrs(3'h2, 16'h0000);
    repeat (3) @(posedge clk_i);
    chk("invalid_hot", 0, sr_valid_o);
    wb(0, 32'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    conclude;
  end
endmodule // tb_top
